// [dv/sps_smb_host.sv]
// SMBus host model that reaches the slot power registers
`timescale 1ns/100ps
module sps_smb_host #(
    parameter logic [6:0] DEV_ADDR = 7'h45 // Target address
) (
    input  wire logic sda_line, // Resolved data wire
    output logic      scl,      // Bus clock, still between frames
    output logic      sda_pull  // High pulls data low
);
    // ==================
    // Bit level
    logic nack_seen = 1'b0;
    initial scl = 1'b1;
    initial sda_pull = 1'b0;
    // Data moves 1 ns after the clock falls: the link tests for a start at that very edge
    task automatic clk_bit(input logic pull_v, output logic seen);
        #1 sda_pull = pull_v;
        #2 scl = 1'b1;
        #1.5 seen = sda_line;
        #1.5 scl = 1'b0;
    endtask
    // Data stays high so the link can leave reset
    task automatic idle(input int n);
        repeat (n) begin
            #3 scl = 1'b0;
            #3 scl = 1'b1;
        end
    endtask
    // Also serves as repeated start
    task automatic start();
        #1 sda_pull = 1'b0;
        #2 scl = 1'b1;
        #3 sda_pull = 1'b1;
        #3 scl = 1'b0;
    endtask
    task automatic stop();
        #1 sda_pull = 1'b1;
        #2 scl = 1'b1;
        #3 sda_pull = 1'b0;
        #3;
    endtask
    task automatic send(input logic [7:0] b);
        logic ack;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(~b[i], ack);
        end
        clk_bit(1'b0, ack);
        if (ack !== 1'b0) nack_seen = 1'b1;
    endtask
    task automatic recv(output logic [7:0] b);
        logic nack;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, b[i]);
        end
        clk_bit(1'b0, nack);
    endtask
    // ==================
    // Byte transfers
    task automatic write_byte(input logic [7:0] cmd, input logic [7:0] data);
        start();
        send({DEV_ADDR, 1'b0});
        send(cmd);
        send(data);
        stop();
    endtask
    task automatic read_byte(input logic [7:0] cmd, output logic [7:0] data);
        start();
        send({DEV_ADDR, 1'b0});
        send(cmd);
        start();
        send({DEV_ADDR, 1'b1});
        recv(data);
        stop();
    endtask
endmodule

// [dv/tb_sps_top.sv]
// Self-checking bench for the slot power status registers
`timescale 1ns/100ps
module tb_sps_top
    import sps_pkg::*;
;
    // ==================
    // Harness
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    logic         scl, pull, sda_out, sda_oe, adc_start, irq_n_out, irq_n_oe;
    logic         am, aa, bm, ba;
    logic         irq_mask = 1'b0;
    logic         adc_done = 1'b0;
    logic [7:0]   adc_value = 8'h00;
    logic [7:0]   rd;
    sps_slot_in_t sa = '0;
    sps_slot_in_t sb = '0;
    sps_adc_sel_t adc_sel;
    int           mismatches = 0;
    int           check_count = 0;
    int           starts = 0;
    wire          sda_in = ~(sda_oe | pull);
    always #4 clock = ~clock;
    always @(negedge clock) if (adc_start === 1'b1) starts++;
    sps_top u_dut (.clock(clock), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_strap(3'h5), .slot_a_in(sa), .slot_b_in(sb), .irq_mask(irq_mask),
        .adc_done(adc_done), .adc_value(adc_value), .adc_sel(adc_sel), .adc_start(adc_start),
        .slot_a_main_en(am), .slot_a_aux_en(aa), .slot_b_main_en(bm), .slot_b_aux_en(ba),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
    sps_smb_host #(.DEV_ADDR(7'h45)) u_host (.sda_line(sda_in), .scl(scl), .sda_pull(pull));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Writes land 2 to 3 clocks after the data byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_host.write_byte(a, d);
        repeat (6) @(negedge clock);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        u_host.read_byte(a, rd);
        check(rd, exp);
        @(negedge clock);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
    // ==================
    // Scenarios
    initial begin
        fork
            u_host.idle(8);
            repeat (8) @(posedge clock);
        join
        @(negedge clock) rst = 1'b0;
        // The link leaves reset only on scl edges
        u_host.idle(4);
        repeat (4) @(negedge clock);
        check({4'h0, am, aa, bm, ba}, 8'h00);
        rdc(8'h02, 8'h00);
        rdc(8'h03, 8'h00);
        rdc(8'h04, 8'h00);
        sa.main_good = 1'b1;
        sb.aux_good = 1'b1;
        wr(8'h02, 8'hFF);
        wr(8'h03, 8'hFE);
        check({4'h0, am, aa, bm, ba}, 8'h0E);
        rdc(8'h02, 8'h43);
        rdc(8'h03, 8'h82);
        sa.fault_pin_state = 1'b1;
        sa.main_on = 1'b1;
        sa.oc = 5'h04;
        repeat (3) @(negedge clock);
        sa.oc = 5'h00;
        repeat (6) @(negedge clock);
        check({7'h0, irq_n_oe}, 8'h01);
        rdc(8'h04, 8'hC4);
        rdc(8'h04, 8'hC4);
        wr(8'h04, 8'hFB);
        rdc(8'h04, 8'hC4);
        wr(8'h04, 8'h04);
        rdc(8'h04, 8'hC0);
        check({7'h0, irq_n_oe}, 8'h00);
        irq_mask = 1'b1;
        sb.aux_on = 1'b1;
        sb.oc = 5'h10;
        repeat (3) @(negedge clock);
        sb.oc = 5'h00;
        repeat (6) @(negedge clock);
        check({7'h0, irq_n_oe}, 8'h00);
        rdc(8'h05, 8'h30);
        irq_mask = 1'b0;
        repeat (6) @(negedge clock);
        check({7'h0, irq_n_oe}, 8'h01);
        wr(8'h05, 8'h10);
        rdc(8'h05, 8'h20);
        check({7'h0, irq_n_oe}, 8'h00);
        for (int s = 1; s <= 5; s++) begin
            wr(8'h01, {3'h0, s[1:0], s[2:0]});
            check({3'h0, adc_sel}, {3'h0, s[1:0], s[2:0]});
        end
        check(starts[7:0], 8'h05);
        wr(8'h01, 8'h00);
        rdc(8'h01, 8'h00);
        adc_value = 8'h5A;
        wr(8'h01, 8'h1B);
        rdc(8'h01, 8'h9B);
        adc_done = 1'b1;
        for (int i = 0; i < 20 && rd[7] !== 1'b0; i++) u_host.read_byte(8'h01, rd);
        check(rd, 8'h1B);
        if (rd[7] !== 1'b0) final_report();
        @(negedge clock);
        rdc(8'h00, 8'h5A);
        wr(8'h07, 8'hFF);
        rdc(8'h07, 8'h00);
        check({7'h0, u_host.nack_seen}, 8'h00);
        check({6'h0, sda_out, irq_n_out}, 8'h00);
        // Second reset with both slots enabled
        rst = 1'b1;
        fork
            u_host.idle(8);
            repeat (8) @(negedge clock);
        join
        rst = 1'b0;
        u_host.idle(4);
        repeat (4) @(negedge clock);
        check({4'h0, am, aa, bm, ba}, 8'h00);
        rdc(8'h02, 8'h40);
        rdc(8'h03, 8'h80);
        final_report();
    end
endmodule

// [rtl/sps_pkg.sv]
// Constants and types for the slot power status register block
// Summary of operation
// - After busy clears, the result register holds the valid conversion value; a 000 setup write clears busy without storing one.
// - Slot A control: main enable bit 1, aux enable bit 0, good flags 7:6.
// - Slot B control uses the same layout as slot A.
// - Slot A control resets to zero, all slot A outputs off.
// - Slot B control resets to zero, all slot B outputs off.
// - Slot A condition: fault pin 7, main 6, aux 5, overcurrent flags 4:0.
// - Slot B condition uses the same bit arrangement as slot A.
// - Main state bit shows the actual state of the four main outputs.
// - Aux state bit shows whether the aux output is actually powered.
// - Each overcurrent flag sets on a fault and stays set until cleared.
// - Writing one to a set flag clears it and releases the interrupt.
// - Reading a condition register leaves the fault pin untouched.
// - adc_setup: slot bit, kind bit, 3-bit supply; 000 means no conversion.
// - Interrupt drives low on any fault flag unless the mask is set.
// - Access is byte read and byte write: address, command, one data byte.
package sps_pkg;

    localparam int       DW       = 8;
    localparam int       OC_W     = 5;
    localparam int       STRAP_W  = 3;
    localparam int       SUP_W    = 3;
    localparam logic [DW-1:0] REG_RESULT      = 8'h00;
    localparam logic [DW-1:0] REG_ADC_SETUP   = 8'h01;
    localparam logic [DW-1:0] REG_SLOT_A_CTRL = 8'h02;
    localparam logic [DW-1:0] REG_SLOT_A_COND = 8'h04;
    localparam logic [DW-1:0] RESET_BYTE      = 8'h00;
    localparam logic [1:0]    CTRL_RESET      = 2'h0;
    localparam int       CTRL_AUX_EN    = 0;
    localparam int       CTRL_MAIN_EN   = 1;
    localparam int       COND_AUX_BIT   = 5;
    localparam int       COND_MAIN_BIT  = 6;
    localparam int       COND_FAULT_BIT = 7;
    localparam logic [SUP_W-1:0] SUP_NONE = 3'h0;
    localparam logic [3:0]       SMB_ADDR_HI = 4'h8;
    localparam logic [2:0]       BIT_LAST    = 3'h7;

    typedef struct packed {
        logic            fault_pin_state;
        logic            main_on;
        logic            aux_on;
        logic            main_good;
        logic            aux_good;
        logic [OC_W-1:0] oc;       // 4 aux, 3 -12V, 2 +12V, 1 +5V, 0 +3.3V
    } sps_slot_in_t;

    typedef struct packed {
        logic             slot;     // 0 slot A, 1 slot B
        logic             measure_kind; // 0 current, 1 voltage
        logic [SUP_W-1:0] sup;      // 1 3.3V, 2 5V, 3 +12V, 4 -12V, 5 aux
    } sps_adc_sel_t;

    typedef struct packed {
        logic [DW-1:0] cmd;
        logic [DW-1:0] data;
    } sps_smb_req_t;

    typedef enum logic [6:0] {
        LS_IDLE   = 7'h01,
        LS_ADDR   = 7'h02,
        LS_CMD    = 7'h04,
        LS_WDATA  = 7'h08,
        LS_RDATA  = 7'h10,
        LS_RACK   = 7'h20,
        LS_IGNORE = 7'h40
    } sps_link_state_t;

endpackage

// [rtl/sps_slot_flags.sv]
// Per-slot condition register with sticky overcurrent flags
`timescale 1ns/100ps
module sps_slot_flags
    import sps_pkg::*;
(
    input  wire logic            clock,    // System clock
    input  wire logic            rst,      // Synchronous reset
    input  wire sps_slot_in_t    slot_in,  // Synchronised slot status
    input  wire logic            clr_stb,  // Write to this condition register
    input  wire logic [OC_W-1:0] clr_mask, // Ones clear the matching flags
    output logic      [DW-1:0]   cond_byte // Condition register contents
);
    logic [OC_W-1:0] flags_reg;
    logic [OC_W-1:0] flags_next;
    logic [2:0]      state_reg;

    // A fault in the clearing cycle survives the clear
    always_comb begin
        flags_next = (flags_reg & ~(clr_stb ? clr_mask : '0)) | slot_in.oc;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // Reported states track the outputs, not the enables
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= {slot_in.fault_pin_state, slot_in.main_on, slot_in.aux_on};
        end
    end

    assign cond_byte = {state_reg, flags_reg};
endmodule

// [rtl/sps_sync.sv]
// Two-flop synchroniser for a bundle of levels
`timescale 1ns/100ps
module sps_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock, // Destination clock
    input  wire logic [WIDTH-1:0] d,     // Asynchronous levels
    output logic      [WIDTH-1:0] q      // Synchronised levels
);
    logic [WIDTH-1:0] meta_reg;

    // No reset: the chain flushes in two edges
    always_ff @(posedge clock) begin
        meta_reg <= d;
        q        <= meta_reg;
    end
endmodule

// [rtl/sps_top.sv]
// Top level: SMBus-reached slot power control and status registers
`timescale 1ns/100ps
module sps_top
    import sps_pkg::*;
(
    input  wire logic         clock,          // System clock, 125 MHz
    input  wire logic         rst,            // Synchronous reset, active high
    input  wire logic         scl,            // SMBus clock from the host
    input  wire logic         sda_in,         // SMBus data wire level
    output logic              sda_out,        // SMBus data drive value
    output logic              sda_oe,         // SMBus data pull-down enable
    input  wire logic [2:0]   addr_strap,     // Slave address low bits
    input  wire sps_slot_in_t slot_a_in,      // Slot A power-side status
    input  wire sps_slot_in_t slot_b_in,      // Slot B power-side status
    input  wire logic         irq_mask,       // High keeps the interrupt off
    input  wire logic         adc_done,       // Rises when a conversion ends
    input  wire logic [7:0]   adc_value,      // Converter output byte
    output sps_adc_sel_t      adc_sel,        // Channel for the converter
    output logic              adc_start,      // One-cycle conversion request
    output logic              slot_a_main_en, // Slot A main outputs enable
    output logic              slot_a_aux_en,  // Slot A aux output enable
    output logic              slot_b_main_en, // Slot B main outputs enable
    output logic              slot_b_aux_en,  // Slot B aux output enable
    output logic              irq_n_out,      // Interrupt drive value
    output logic              irq_n_oe        // Interrupt pull-down enable
);

    // ==========================================================
    // Link side, clocked by the host's SMBus clock
    // ==========================================================
    sps_link_state_t state_reg;
    logic            link_rst;
    logic            sda_hi_reg;
    logic [2:0]      bit_cnt_reg;
    logic [DW-1:0]   shift_reg;
    logic            ack_reg;
    logic            drive_reg;
    logic [DW-1:0]   cmd_reg;
    logic [DW-1:0]   wr_data_reg;
    logic            wr_tgl_reg;
    logic            rd_tgl_reg;
    logic [DW-1:0]   byte_in;
    logic            start_seen;
    logic [DW-1:0]   rd_data_reg;
    logic [STRAP_W-1:0] strap_reg;
    sps_smb_req_t    link_req;

    sps_sync #(
        .WIDTH (1)
    ) u_link_rst (
        .clock (scl),
        .d     (rst),
        .q     (link_rst)
    );

    // Data is stable while the clock is high
    always_ff @(posedge scl) begin
        sda_hi_reg <= sda_in;
    end

    assign byte_in    = {shift_reg[DW-2:0], sda_hi_reg};
    // Data falling inside a clock-high phase is a (repeated) start
    assign start_seen = sda_hi_reg & ~sda_in;

    always_ff @(negedge scl) begin
        if (link_rst) begin
            state_reg   <= LS_IDLE;
            bit_cnt_reg <= '0;
            shift_reg   <= '0;
            ack_reg     <= 1'b0;
            drive_reg   <= 1'b0;
            cmd_reg     <= '0;
            wr_data_reg <= '0;
            wr_tgl_reg  <= 1'b0;
            rd_tgl_reg  <= 1'b0;
        end else if (start_seen) begin
            state_reg   <= LS_ADDR;
            bit_cnt_reg <= '0;
            ack_reg     <= 1'b0;
            drive_reg   <= 1'b0;
        end else if (ack_reg) begin
            ack_reg     <= 1'b0;
            bit_cnt_reg <= '0;
            if (state_reg == LS_RDATA) begin
                shift_reg <= rd_data_reg;
                drive_reg <= ~rd_data_reg[DW-1];
            end else begin
                drive_reg <= 1'b0;
            end
        end else if (state_reg == LS_IDLE && !sda_in) begin
            // Start after a stop: no high sample precedes it
            state_reg   <= LS_ADDR;
            bit_cnt_reg <= '0;
            drive_reg   <= 1'b0;
        end else begin
            unique case (state_reg)
                LS_IDLE, LS_IGNORE: begin
                    drive_reg <= 1'b0;
                end
                LS_ADDR, LS_CMD, LS_WDATA: begin
                    shift_reg <= byte_in;
                    if (bit_cnt_reg != BIT_LAST) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end else if (state_reg == LS_ADDR) begin
                        if (byte_in[DW-1:1] == {SMB_ADDR_HI, strap_reg}) begin
                            ack_reg   <= 1'b1;
                            drive_reg <= 1'b1;
                            state_reg <= byte_in[0] ? LS_RDATA : LS_CMD;
                        end else begin
                            state_reg <= LS_IGNORE;
                        end
                    end else if (state_reg == LS_CMD) begin
                        cmd_reg    <= byte_in;
                        rd_tgl_reg <= ~rd_tgl_reg;
                        ack_reg    <= 1'b1;
                        drive_reg  <= 1'b1;
                        state_reg  <= LS_WDATA;
                    end else begin
                        wr_data_reg <= byte_in;
                        wr_tgl_reg  <= ~wr_tgl_reg;
                        ack_reg     <= 1'b1;
                        drive_reg   <= 1'b1;
                        state_reg   <= LS_IDLE;
                    end
                end
                LS_RDATA: begin
                    if (bit_cnt_reg != BIT_LAST) begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        shift_reg   <= {shift_reg[DW-2:0], 1'b0};
                        drive_reg   <= ~shift_reg[DW-2];
                    end else begin
                        drive_reg <= 1'b0;
                        state_reg <= LS_RACK;
                    end
                end
                LS_RACK: begin
                    state_reg <= LS_IDLE;
                end
                default: begin
                    state_reg <= LS_IDLE;
                    drive_reg <= 1'b0;
                end
            endcase
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = drive_reg;

    // ==========================================================
    // Crossing into the system clock
    // ==========================================================
    localparam int SYNC_W = 2 + DW + 2 + STRAP_W + 2 * $bits(sps_slot_in_t);

    logic [SYNC_W-1:0]    raw_in;
    logic [SYNC_W-1:0]    sync_out;
    logic                 rd_tgl_s;
    logic                 wr_tgl_s;
    logic [DW-1:0]        adc_value_s;
    logic                 adc_done_s;
    logic                 irq_mask_s;
    logic [STRAP_W-1:0]   strap_s;
    sps_slot_in_t [1:0]   slot_s;
    logic                 wr_seen_reg;
    logic                 rd_seen_reg;
    logic                 done_seen_reg;
    logic                 wr_evt;
    logic                 rd_evt;
    logic                 done_rise;

    // Value settles before done rises, so both arrive together
    assign raw_in = {rd_tgl_reg, wr_tgl_reg, adc_value, adc_done,
                     irq_mask, addr_strap, slot_b_in, slot_a_in};

    sps_sync #(
        .WIDTH (SYNC_W)
    ) u_sys_sync (
        .clock (clock),
        .d     (raw_in),
        .q     (sync_out)
    );

    assign {rd_tgl_s, wr_tgl_s, adc_value_s, adc_done_s,
            irq_mask_s, strap_s, slot_s} = sync_out;

    always_ff @(posedge clock) begin
        // Tracking through reset keeps a stale toggle or a high done from looking like an edge at release
        if (rst) begin
            wr_seen_reg   <= wr_tgl_s;
            rd_seen_reg   <= rd_tgl_s;
            done_seen_reg <= adc_done_s;
        end else begin
            wr_seen_reg   <= wr_tgl_s;
            rd_seen_reg   <= rd_tgl_s;
            done_seen_reg <= adc_done_s;
        end
    end

    assign wr_evt    = wr_tgl_s ^ wr_seen_reg;
    assign rd_evt    = rd_tgl_s ^ rd_seen_reg;
    assign done_rise = adc_done_s & ~done_seen_reg;

    // Command and data hold still for a whole byte after the toggle
    assign link_req = '{cmd: cmd_reg, data: wr_data_reg};

    // Straps are followed through reset and frozen at its release
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_reg <= strap_s;
        end
    end

    // ==========================================================
    // Slot control and condition registers
    // ==========================================================
    logic [1:0][1:0]    ctrl_reg;
    logic [1:0][DW-1:0] cond_byte;

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reg <= {CTRL_RESET, CTRL_RESET};
        end else begin
            for (int i = 0; i < 2; i++) begin
                // Only the two enables are writable
                if (wr_evt && link_req.cmd == REG_SLOT_A_CTRL + 8'(i)) begin
                    ctrl_reg[i] <= link_req.data[1:0];
                end
            end
        end
    end

    for (genvar s = 0; s < 2; s++) begin : g_slot
        sps_slot_flags u_flags (
            .clock     (clock),
            .rst       (rst),
            .slot_in   (slot_s[s]),
            .clr_stb   (wr_evt && link_req.cmd == REG_SLOT_A_COND + 8'(s)),
            .clr_mask  (link_req.data[OC_W-1:0]),
            .cond_byte (cond_byte[s])
        );
    end

    assign slot_a_main_en = ctrl_reg[0][CTRL_MAIN_EN];
    assign slot_a_aux_en  = ctrl_reg[0][CTRL_AUX_EN];
    assign slot_b_main_en = ctrl_reg[1][CTRL_MAIN_EN];
    assign slot_b_aux_en  = ctrl_reg[1][CTRL_AUX_EN];

    // ==========================================================
    // Converter sequencing
    // ==========================================================
    sps_adc_sel_t  setup_reg;
    logic          busy_reg;
    logic          start_reg;
    logic [DW-1:0] result_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            setup_reg <= '0;
            busy_reg  <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (wr_evt && link_req.cmd == REG_ADC_SETUP) begin
                setup_reg <= link_req.data[$bits(sps_adc_sel_t)-1:0];
                // Writing no-conversion cancels a pending result
                busy_reg  <= link_req.data[SUP_W-1:0] != SUP_NONE;
                start_reg <= link_req.data[SUP_W-1:0] != SUP_NONE;
            end else if (done_rise) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // Result is not reset, matching an undefined power-up value
    always_ff @(posedge clock) begin
        if (done_rise && busy_reg) begin
            result_reg <= adc_value_s;
        end
    end

    assign adc_sel   = setup_reg;
    assign adc_start = start_reg;

    // ==========================================================
    // Read path and interrupt
    // ==========================================================
    function automatic logic [DW-1:0] read_byte(input logic [DW-1:0] off);
        logic [DW-1:0] v;
        v = RESET_BYTE;
        for (int i = 0; i < 2; i++) begin
            if (off == REG_SLOT_A_CTRL + 8'(i)) begin
                v = {slot_s[i].aux_good, slot_s[i].main_good, 4'h0, ctrl_reg[i]};
            end
            if (off == REG_SLOT_A_COND + 8'(i)) begin
                v = cond_byte[i];
            end
        end
        if (off == REG_RESULT) begin
            v = result_reg;
        end
        if (off == REG_ADC_SETUP) begin
            v = {busy_reg, 2'h0, setup_reg};
        end
        return v;
    endfunction

    // Snapshot taken when the command byte lands; reads change nothing
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data_reg <= RESET_BYTE;
        end else if (rd_evt) begin
            rd_data_reg <= read_byte(link_req.cmd);
        end
    end

    logic pending;
    logic irq_reg;

    assign pending = |{cond_byte[0][OC_W-1:0], cond_byte[1][OC_W-1:0]};

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= pending & ~irq_mask_s;
        end
    end

    assign irq_n_out = 1'b0;
    assign irq_n_oe  = irq_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    AST_CTRL_A_RESET: assert property (@(posedge clock)
        $fell(rst) |-> !slot_a_main_en && !slot_a_aux_en)
        else $error("slot A enables not off after reset");

    AST_CTRL_B_RESET: assert property (@(posedge clock)
        $fell(rst) |-> !slot_b_main_en && !slot_b_aux_en)
        else $error("slot B enables not off after reset");

    AST_CTRL_A_WRITE: assert property (@(posedge clock) disable iff (rst)
        wr_evt && link_req.cmd == REG_SLOT_A_CTRL
        |=> {slot_a_main_en, slot_a_aux_en} == $past(link_req.data[1:0]))
        else $error("slot A enables did not take written value");

    AST_CTRL_B_WRITE: assert property (@(posedge clock) disable iff (rst)
        wr_evt && link_req.cmd == REG_SLOT_A_CTRL + 8'h01
        |=> {slot_b_main_en, slot_b_aux_en} == $past(link_req.data[1:0]))
        else $error("slot B enables did not take written value");

    AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (rst)
        (read_byte(REG_SLOT_A_CTRL) & 8'h3C) == 8'h00 && (read_byte(REG_ADC_SETUP) & 8'h60) == 8'h00)
        else $error("reserved bits read nonzero");

    AST_BUSY_SET: assert property (@(posedge clock) disable iff (rst)
        wr_evt && link_req.cmd == REG_ADC_SETUP && link_req.data[SUP_W-1:0] != SUP_NONE
        |=> busy_reg && adc_start ##1 !adc_start)
        else $error("busy or start missing after setup write");

    AST_RESULT: assert property (@(posedge clock) disable iff (rst)
        busy_reg && done_rise && !wr_evt
        |=> !busy_reg && result_reg == $past(adc_value_s))
        else $error("result not stored when busy cleared");

    AST_OC_STICKY: assert property (@(posedge clock) disable iff (rst)
        cond_byte[0][0] && !(wr_evt && link_req.cmd == REG_SLOT_A_COND)
        |=> cond_byte[0][0])
        else $error("overcurrent flag dropped without a clear");

    AST_OC_CLEAR: assert property (@(posedge clock) disable iff (rst)
        wr_evt && link_req.cmd == REG_SLOT_A_COND && link_req.data[0] && !slot_s[0].oc[0]
        |=> !cond_byte[0][0])
        else $error("overcurrent flag not cleared by a one");

    AST_IRQ: assert property (@(posedge clock) disable iff (rst)
        irq_n_oe == $past(pending && !irq_mask_s))
        else $error("interrupt does not follow flags and mask");

    AST_MAIN_STATE: assert property (@(posedge clock) disable iff (rst)
        ##1 cond_byte[1][COND_MAIN_BIT] == $past(slot_s[1].main_on))
        else $error("main state bit does not track the outputs");

endmodule
